// *** logic/scl_pkg.sv ***
// Shared constants and types for the command legality block.
// Assumes a single 40 MHz clock and an active low asynchronous reset.
`default_nettype none
package scl_pkg;
	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 25; // 40 MHz
	localparam int LAST_DATA_TO_IDLE_NS = 50; // Write recovery with auto-close
	localparam int ROW_CLOSE_NS = 30; // Refresh busy time
	localparam int ROW_CYCLE_NS = 90; // Self-retention recovery
	localparam int SETUP_LOAD_CYCLES = 2; // Setup register load delay
	localparam int LAST_DATA_TO_IDLE_CYC =
		(LAST_DATA_TO_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_CLOSE_CYC = (ROW_CLOSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8; // Wait counter width
	// ==========================================================
	// Pin widths and field positions
	// ==========================================================
	localparam int ADDR_W = 12; // A0..A11
	localparam int BANK_BIT = 11; // A11 selects bank
	localparam int CLOSE_ALL_BIT = 10; // A10 selects every row on close
	localparam int AUTOCLOSE_BIT = 10; // A10 selects auto-close on column cmds
	localparam int BL_LSB = 0; // Burst length field
	localparam int BL_W = 3;
	localparam logic [2:0] BL_FULL_PAGE = 3'h7;
	localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
	// ==========================================================
	// Commands, coded cs_n ras_n cas_n we_n
	// ==========================================================
	typedef enum logic [3:0] {
		SCL_DESELECT = 4'h0,
		SCL_IDLE_CYCLE = 4'h1,
		SCL_BURST_HALT = 4'h2,
		SCL_READ = 4'h3,
		SCL_WRITE = 4'h4,
		SCL_ROW_OPEN = 4'h5,
		SCL_ROW_CLOSE = 4'h6,
		SCL_REFRESH = 4'h7,
		SCL_SETUP_LOAD = 4'h8
	} scl_cmd_t;
	// Device wide states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_REFRESH = 7'h02,
		ST_SETUP = 7'h04,
		ST_POWER_DOWN = 7'h08,
		ST_SELF_RET = 7'h10,
		ST_SELF_REC = 7'h20,
		ST_BANKS = 7'h40
	} scl_state_t;
	// Per-bank states, one-hot
	typedef enum logic [2:0] {
		BK_IDLE = 3'h1,
		BK_ACTIVE = 3'h2,
		BK_WR_AUTOCLOSE = 3'h4
	} scl_bank_t;
endpackage
`default_nettype wire

// *** logic/scl_cmd_decode.sv ***
// Decodes the four strobe pins into a command code.
// Assumes pins are sampled synchronously by the parent.
`default_nettype none
module scl_cmd_decode
	import scl_pkg::*;
(
	// Strobes
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	// Decoded command
	output scl_pkg::scl_cmd_t cmd
);
	// ==========================================================
	// Decode
	// ==========================================================
	// strobe pin encoding
	always_comb begin
		if (cs_n) begin
			cmd = SCL_DESELECT;
		end else begin
			unique case ({ras_n, cas_n, we_n})
				3'h7: cmd = SCL_IDLE_CYCLE;
				3'h6: cmd = SCL_BURST_HALT;
				3'h5: cmd = SCL_READ;
				3'h4: cmd = SCL_WRITE;
				3'h3: cmd = SCL_ROW_OPEN;
				3'h2: cmd = SCL_ROW_CLOSE;
				3'h1: cmd = SCL_REFRESH;
				default: cmd = SCL_SETUP_LOAD;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** logic/scl_wait_timer.sv ***
// Down counter that loads a wait and flags its last counted cycle.
// Assumes load takes priority over counting.
`default_nettype none
module scl_wait_timer
	import scl_pkg::*;
#(
	parameter int W = scl_pkg::CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic load,
	input wire logic [W-1:0] value,
	// Status
	output logic done
);
	logic [W-1:0] cnt_reg; // Remaining cycles
	// ==========================================================
	// Counter
	// ==========================================================
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= value;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end
	// Done on the last counted edge, so a wait of N leaves after N edges
	assign done = (cnt_reg <= W'(1)) && !load;
endmodule
`default_nettype wire

// *** logic/scl_state_legality.sv ***
// Command legality and state tracking for a two-bank synchronous DRAM.
// Assumes the controller meets open-to-column, bank gap and row-open
// minimum times; these are not tracked here.
// Overview of operation
// - Write auto-close: idle after last-data time
// - Refresh: no-ops, idle after row-close time
// - Setup load: only no-ops until delay
// - Four strobe pins encode nine commands
// - Every input but resetn sampled on rising edge
// - Setup load stores A0..A11 as opcode
// - Refresh ignores address and data pins
// - Self-retention ignores all but clock gate and command at gate rise
// - Burst halt valid only at full page; refresh and setup waits accept it at any length
// - Gate low, both idle: power-down
// - Refresh with gate low: self-retention
// - Auto-close closes bank after burst
// - Self-retention exit and recovery via gate
// - Gate drop in recovery: power-down next
// - Gate rise ends clock suspend next cycle
// - Gate rise wakes inputs; setup wait
// - Gate rise ends power-down to idle
`default_nettype none
module scl_state_legality
	import scl_pkg::*;
#(
	parameter int BURST_W = 4 // Burst length counter width
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Command pins
	input wire logic clock_gate_in,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [scl_pkg::ADDR_W-1:0] addr,
	// Status
	output scl_pkg::scl_state_t dev_state,
	output logic [1:0] bank_idle,
	output logic [scl_pkg::ADDR_W-1:0] mode_reg,
	output logic illegal_cmd,
	output logic clock_suspended
);
	import scl_pkg::*;
	// ==========================================================
	// Input capture and decode
	// ==========================================================
	scl_cmd_t cmd; // Decoded command
	logic gate_prev_reg; // Clock gate sample n-1
	logic burst_ok; // Burst halt accepted
	scl_state_t state_reg; // Device state
	scl_state_t state_next;
	scl_bank_t bank_reg [2]; // Per-bank state
	logic [BURST_W-1:0] burst_reg [2]; // Remaining burst beats
	logic [ADDR_W-1:0] mode_reg_reg; // Operating code
	logic suspend_reg; // Clock suspend flag
	logic illegal_reg; // Registered illegal flag
	logic illegal_next;
	logic wait_load; // Global timer load
	logic [CNT_W-1:0] wait_val;
	logic wait_done;
	logic [1:0] wr_load; // Per-bank write recovery load
	logic [1:0] wr_done;
	logic sel_bank; // Bank from A11
	logic both_idle;
	logic nop_like; // Deselect, idle cycle or halt
	logic quiet; // Deselect or idle cycle
	// all pins taken as synchronous to the clock edge
	scl_cmd_decode u_dec (
		.cs_n(chip_select_n),
		.ras_n(row_strobe_n),
		.cas_n(column_strobe_n),
		.we_n(write_strobe_n),
		.cmd(cmd)
	);
	assign sel_bank = addr[BANK_BIT];
	assign both_idle = (bank_reg[0] == BK_IDLE) && (bank_reg[1] == BK_IDLE);
	assign nop_like = (cmd == SCL_DESELECT) || (cmd == SCL_IDLE_CYCLE)
		|| (cmd == SCL_BURST_HALT);
	assign quiet = (cmd == SCL_DESELECT) || (cmd == SCL_IDLE_CYCLE);
	// burst halt only with full page length, checked in idle and bank states
	assign burst_ok = mode_reg_reg[BL_LSB +: BL_W] == BL_FULL_PAGE;
	// ==========================================================
	// Timers
	// ==========================================================
	scl_wait_timer #(.W(CNT_W)) u_wait (
		.clk(clk),
		.resetn(resetn),
		.load(wait_load),
		.value(wait_val),
		.done(wait_done)
	);
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_bank_tmr
			scl_wait_timer #(.W(CNT_W)) u_wr (
				.clk(clk),
				.resetn(resetn),
				.load(wr_load[gi]),
				.value(CNT_W'(LAST_DATA_TO_IDLE_CYC)),
				.done(wr_done[gi])
			);
		end
	endgenerate
	// ==========================================================
	// Clock gate history
	// ==========================================================
	// Previous sample kept for the n-1 / n judgement
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gate_prev_reg <= 1'b1;
		end else begin
			gate_prev_reg <= clock_gate_in;
		end
	end
	// rising gate ends suspend on the next cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			suspend_reg <= 1'b0;
		end else if (state_reg == ST_BANKS && !clock_gate_in) begin
			suspend_reg <= 1'b1;
		end else if (clock_gate_in) begin
			suspend_reg <= 1'b0;
		end
	end
	// ==========================================================
	// Device state machine
	// ==========================================================
	always_comb begin
		state_next = state_reg;
		illegal_next = 1'b0;
		wait_load = 1'b0;
		wait_val = '0;
		unique case (state_reg)
			ST_IDLE: begin
				// refresh with gate dropping enters self-retention
				if (!clock_gate_in && cmd == SCL_REFRESH) begin
					state_next = ST_SELF_RET;
				// gate low with banks idle powers down
				end else if (!clock_gate_in) begin
					state_next = ST_POWER_DOWN;
				end else if (cmd == SCL_REFRESH) begin
					state_next = ST_REFRESH;
					wait_load = 1'b1;
					wait_val = CNT_W'(ROW_CLOSE_CYC);
				end else if (cmd == SCL_SETUP_LOAD) begin
					state_next = ST_SETUP;
					wait_load = 1'b1;
					wait_val = CNT_W'(SETUP_LOAD_CYCLES);
				end else if (cmd == SCL_ROW_OPEN) begin
					state_next = ST_BANKS;
				end else if (cmd == SCL_BURST_HALT && !burst_ok) begin
					illegal_next = 1'b1;
				end else if (!nop_like && cmd != SCL_ROW_CLOSE) begin
					illegal_next = 1'b1;
				end
			end
			ST_REFRESH: begin
				if (!nop_like) begin
					illegal_next = 1'b1;
				end
				if (wait_done) begin
					state_next = ST_IDLE;
				end
			end
			ST_SETUP: begin
				if (!nop_like) begin
					illegal_next = 1'b1;
				end
				if (wait_done) begin
					state_next = ST_IDLE;
				end
			end
			// gate rise leaves power-down to idle
			// inputs are watched again from the next edge
			ST_POWER_DOWN: begin
				if (clock_gate_in) begin
					state_next = ST_IDLE;
				end
			end
			// only the clock gate is watched here, plus the command on its rising edge
			ST_SELF_RET: begin
				// low-to-high with quiet command starts recovery
				if (!gate_prev_reg && clock_gate_in) begin
					if (quiet) begin
						state_next = ST_SELF_REC;
						wait_load = 1'b1;
						wait_val = CNT_W'(ROW_CYCLE_CYC);
					end else begin
						illegal_next = 1'b1;
					end
				end
			end
			ST_SELF_REC: begin
				// gate drop with quiet command powers down
				if (!clock_gate_in) begin
					if (quiet) begin
						state_next = ST_POWER_DOWN;
					end else begin
						illegal_next = 1'b1;
					end
				// idle once the row cycle time is spent
				end else begin
					if (!quiet) begin
						illegal_next = 1'b1;
					end
					if (wait_done) begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_BANKS: begin
				// global commands need both banks idle
				if (cmd == SCL_REFRESH || cmd == SCL_SETUP_LOAD) begin
					illegal_next = 1'b1;
				// bank commands refused while that bank recovers
				end else if ((cmd == SCL_READ || cmd == SCL_WRITE || cmd == SCL_ROW_OPEN
					|| cmd == SCL_ROW_CLOSE) && bank_reg[sel_bank] == BK_WR_AUTOCLOSE) begin
					illegal_next = 1'b1;
				end else if (cmd == SCL_BURST_HALT && !burst_ok) begin
					illegal_next = 1'b1;
				end
				if (both_idle && !clock_gate_in) begin
					state_next = ST_POWER_DOWN;
				end else if (both_idle && cmd != SCL_ROW_OPEN) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end
	// Device state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end
	// ==========================================================
	// Bank tracking
	// ==========================================================
	// Banks move only while the device runs bank commands; auto-close recovery ends in any state
	generate
		for (gi = 0; gi < 2; gi++) begin : g_bank
			logic hit;
			logic active_ctx;
			assign hit = (sel_bank == 1'(gi));
			assign active_ctx = (state_reg == ST_IDLE || state_reg == ST_BANKS)
				&& clock_gate_in;
			// auto-close write burst starts recovery timer at burst end
			assign wr_load[gi] = (bank_reg[gi] == BK_ACTIVE) && (burst_reg[gi] ==
				BURST_W'(1)) && active_ctx;
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					bank_reg[gi] <= BK_IDLE;
					burst_reg[gi] <= '0;
				end else if (bank_reg[gi] == BK_WR_AUTOCLOSE) begin
					// bank returns to idle after last-data time
					if (wr_done[gi]) begin
						bank_reg[gi] <= BK_IDLE;
					end
				end else if (active_ctx) begin
					if (burst_reg[gi] != '0) begin
						burst_reg[gi] <= burst_reg[gi] - 1'b1;
						if (burst_reg[gi] == BURST_W'(1)) begin
							bank_reg[gi] <= BK_WR_AUTOCLOSE;
						end
					end
					if (cmd == SCL_ROW_OPEN && hit) begin
						bank_reg[gi] <= BK_ACTIVE;
					end else if (cmd == SCL_ROW_CLOSE
						&& (hit || addr[CLOSE_ALL_BIT])) begin
						bank_reg[gi] <= BK_IDLE;
					end else if ((cmd == SCL_READ || cmd == SCL_WRITE) && hit
						&& addr[AUTOCLOSE_BIT] && bank_reg[gi] == BK_ACTIVE) begin
						burst_reg[gi] <= BURST_W'(1) << mode_reg_reg[1:0];
					end
				end
			end
			assign bank_idle[gi] = (bank_reg[gi] == BK_IDLE);
		end
	endgenerate
	// ==========================================================
	// Mode register and illegal flag
	// ==========================================================
	// setup load stores the address pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg_reg <= MODE_RESET;
		end else if (state_reg == ST_IDLE && clock_gate_in && cmd == SCL_SETUP_LOAD) begin
			mode_reg_reg <= addr;
		end
	end
	// Illegal command flag, set on the offending edge and held one cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			illegal_reg <= 1'b0;
		end else begin
			illegal_reg <= illegal_next;
		end
	end
	assign dev_state = state_reg;
	assign mode_reg = mode_reg_reg;
	assign illegal_cmd = illegal_reg;
	assign clock_suspended = suspend_reg;
	// ==========================================================
	// Checks
	// ==========================================================
	sequence refresh_start_s;
		state_reg == ST_IDLE && clock_gate_in && cmd == SCL_REFRESH;
	endsequence
	refresh_busy_a: assert property (@(posedge clk) disable iff (!resetn)
		refresh_start_s |=> state_reg == ST_REFRESH)
		else $error("refresh not entered");
	setup_load_a: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_IDLE && clock_gate_in && cmd == SCL_SETUP_LOAD
		|=> mode_reg == $past(addr) && state_reg == ST_SETUP)
		else $error("setup load not stored");
	setup_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_SETUP && !nop_like |=> illegal_cmd)
		else $error("illegal in setup not flagged");
	power_down_a: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_IDLE && !clock_gate_in && cmd != SCL_REFRESH
		|=> state_reg == ST_POWER_DOWN)
		else $error("power-down not entered");
	self_ret_a: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_IDLE && !clock_gate_in && cmd == SCL_REFRESH
		|=> state_reg == ST_SELF_RET)
		else $error("self-retention not entered");
	pd_exit_a: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_POWER_DOWN && clock_gate_in |=> state_reg == ST_IDLE)
		else $error("power-down exit missing");
	rec_drop_a: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_SELF_REC && !clock_gate_in && quiet
		|=> state_reg == ST_POWER_DOWN)
		else $error("recovery drop not handled");
	suspend_end_a: assert property (@(posedge clk) disable iff (!resetn)
		clock_gate_in |=> !clock_suspended)
		else $error("suspend not ended");
	halt_check_a: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_IDLE && clock_gate_in && cmd == SCL_BURST_HALT && !burst_ok
		|=> illegal_cmd)
		else $error("halt without full page accepted");
endmodule
`default_nettype wire

// *** tb/scl_ctrl_model.sv ***
// Memory controller model: turns a requested command into pin levels.
// Assumes the bench changes requests a little after each rising edge.
`default_nettype none
module scl_ctrl_model
	import scl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Requests from the bench
	input wire scl_pkg::scl_cmd_t req_cmd,
	input wire logic [scl_pkg::ADDR_W-1:0] req_addr,
	input wire logic req_gate,
	// Pins towards the device
	output logic clock_gate_in,
	output logic chip_select_n,
	output logic row_strobe_n,
	output logic column_strobe_n,
	output logic write_strobe_n,
	output logic [scl_pkg::ADDR_W-1:0] addr
);
	// ==========================================================
	// Ignored lines
	// ==========================================================
	logic flip_reg = 1'b0; // Toggles so ignored strobes never sit still
	logic [ADDR_W-1:0] last_addr_reg = 12'h000; // Last address that mattered
	logic [3:0] strobes; // Chip select, row, column, write
	logic uses_addr; // Command carries an address
	// refresh sends no address, so the lines show the inverse of the last used address
	assign uses_addr = req_cmd inside {SCL_READ, SCL_WRITE, SCL_ROW_OPEN,
		SCL_ROW_CLOSE, SCL_SETUP_LOAD};
	// Pattern and address history
	always_ff @(posedge clk) begin
		flip_reg <= ~flip_reg;
		if (uses_addr) begin
			last_addr_reg <= req_addr;
		end
	end
	// ==========================================================
	// Command encoding
	// ==========================================================
	// four strobe encoding
	// the bench also sends illegal requests on purpose
	// this model passes them on unchanged and adds no timing of its own
	always_comb begin
		case (req_cmd)
			SCL_IDLE_CYCLE: strobes = 4'h7;
			SCL_BURST_HALT: strobes = 4'h6;
			SCL_READ: strobes = 4'h5;
			SCL_WRITE: strobes = 4'h4;
			SCL_ROW_OPEN: strobes = 4'h3;
			SCL_ROW_CLOSE: strobes = 4'h2;
			SCL_REFRESH: strobes = 4'h1;
			SCL_SETUP_LOAD: strobes = 4'h0;
			// Deselected: the other strobes carry no meaning
			default: strobes = {1'b1, {3{flip_reg}}};
		endcase
	end
	assign {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = strobes;
	assign addr = uses_addr ? req_addr : ~last_addr_reg;
	assign clock_gate_in = req_gate;
endmodule
`default_nettype wire

// *** tb/test_sdram_state_command_legality.sv ***
// Self-checking bench for the command legality block.
// Assumes the design package and the controller model are compiled first.
`default_nettype none
module test_sdram_state_command_legality
	import scl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Signals
	// ==========================================================
	logic clk = 1'b0;
	logic resetn = 1'b0; // Active low
	scl_cmd_t req_cmd = SCL_DESELECT;
	logic [11:0] req_addr = 12'h000;
	logic req_gate = 1'b1;
	logic gate, cs_n, ras_n, cas_n, we_n;
	logic [11:0] addr, mode_reg, exp_mode;
	scl_state_t dev_state;
	logic [1:0] bank_idle;
	logic illegal_cmd, clock_suspended;
	int fails = 0;
	int num_checks = 0;
	// Clock generator
	always #12.5 clk = ~clk;
	// ==========================================================
	// Instances
	// ==========================================================
	scl_ctrl_model u_ctrl (.clk(clk), .req_cmd(req_cmd), .req_addr(req_addr),
		.req_gate(req_gate), .clock_gate_in(gate), .chip_select_n(cs_n),
		.row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_strobe_n(we_n),
		.addr(addr));
	scl_state_legality u_dut (.clk(clk), .resetn(resetn), .clock_gate_in(gate),
		.chip_select_n(cs_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
		.write_strobe_n(we_n), .addr(addr), .dev_state(dev_state),
		.bank_idle(bank_idle), .mode_reg(mode_reg), .illegal_cmd(illegal_cmd),
		.clock_suspended(clock_suspended));
	// ==========================================================
	// Shared tasks
	// ==========================================================
	// Compare and count
	task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	// One command per edge; results are settled on return
	task automatic step(input scl_cmd_t c, input logic [11:0] a, input logic g);
		req_cmd = c;
		req_addr = a;
		req_gate = g;
		@(posedge clk);
		#2;
	endtask
	// Hold reset for eight cycles
	task automatic do_reset();
		resetn = 1'b0;
		req_cmd = SCL_DESELECT;
		req_gate = 1'b1;
		repeat (8) @(posedge clk);
		#2;
		resetn = 1'b1;
		exp_mode = 12'h000;
	endtask
	// Busy for k more edges, idle after the one with last
	task automatic dwell(input scl_state_t s, input int k, input logic g, input scl_cmd_t last);
		for (int i = 0; i < k; i++) begin
			step(i[0] ? SCL_IDLE_CYCLE : SCL_DESELECT, 12'hFFF, g);
			check(dev_state, s, "still busy");
		end
		step(last, 12'h000, g);
		check(dev_state, ST_IDLE, "back to idle");
		check(illegal_cmd, 1'b0, "no-op accepted");
	endtask
	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_reset();
		check(dev_state, ST_IDLE, "reset state");
		check(bank_idle, 2'b11, "reset banks");
		check(mode_reg, 12'h000, "reset opcode");
		check(illegal_cmd, 1'b0, "reset flag");
		$display("reset test done");
	endtask
	// Every refused command in a busy state, then the timed return
	// entered only with both banks idle
	task automatic t_busy(input scl_cmd_t enter, input scl_state_t s, input int n);
		scl_cmd_t bad [6] = '{SCL_READ, SCL_WRITE, SCL_ROW_OPEN, SCL_ROW_CLOSE,
			SCL_REFRESH, SCL_SETUP_LOAD};
		if (enter == SCL_SETUP_LOAD) begin
			exp_mode = 12'h5A3;
		end
		foreach (bad[i]) begin
			step(enter, 12'h5A3, 1'b1);
			check(dev_state, s, "busy entry");
			check(mode_reg, exp_mode, "opcode");
			step(bad[i], 12'hC3C, 1'b1);
			check(illegal_cmd, 1'b1, "refused");
			check(dev_state, s, "refused keeps state");
			check(mode_reg, exp_mode, "opcode kept");
			dwell(s, n - 2, 1'b1, SCL_BURST_HALT);
		end
		$display("busy test %s done", s.name());
	endtask
	// Clock suspend, then write with auto-close
	task automatic t_write();
		// opening an idle bank, no other bank opening
		step(SCL_ROW_OPEN, 12'h000, 1'b1);
		check(bank_idle, 2'b10, "bank 0 open");
		step(SCL_IDLE_CYCLE, 12'h000, 1'b0);
		step(SCL_IDLE_CYCLE, 12'h000, 1'b0);
		check(clock_suspended, 1'b1, "suspended");
		step(SCL_IDLE_CYCLE, 12'h000, 1'b1);
		step(SCL_IDLE_CYCLE, 12'h000, 1'b1);
		check(clock_suspended, 1'b0, "resumed");
		// write to the open bank after several idle cycles
		step(SCL_WRITE, 12'h400, 1'b1);
		// Burst beats follow the stored length field
		repeat (1 << exp_mode[1:0]) step(SCL_DESELECT, 12'h000, 1'b1);
		step(SCL_ROW_OPEN, 12'h000, 1'b1);
		check(illegal_cmd, 1'b1, "open while closing");
		check(bank_idle, 2'b10, "still closing");
		step(SCL_DESELECT, 12'h000, 1'b1);
		check(bank_idle, 2'b11, "closed after burst");
		step(SCL_DESELECT, 12'h000, 1'b1);
		check(dev_state, ST_IDLE, "idle again");
		$display("write test done");
	endtask
	// Power-down entry, ignored inputs and exit
	task automatic t_power();
		step(SCL_BURST_HALT, 12'h000, 1'b1);
		check(illegal_cmd, 1'b1, "halt without full page");
		step(SCL_IDLE_CYCLE, 12'h000, 1'b0);
		check(dev_state, ST_POWER_DOWN, "power-down");
		step(SCL_SETUP_LOAD, 12'h777, 1'b0);
		check(mode_reg, exp_mode, "ignored in power-down");
		step(SCL_IDLE_CYCLE, 12'h000, 1'b1);
		check(dev_state, ST_IDLE, "power-down exit");
		$display("power test done");
	endtask
	// Enter self-retention and prove other pins are ignored
	task automatic enter_self();
		step(SCL_IDLE_CYCLE, 12'h000, 1'b1);
		step(SCL_REFRESH, 12'h000, 1'b0);
		check(dev_state, ST_SELF_RET, "self entry");
		step(SCL_SETUP_LOAD, 12'h0F0, 1'b0);
		check(dev_state, ST_SELF_RET, "still retained");
		check(mode_reg, exp_mode, "opcode ignored");
	endtask
	task automatic t_self();
		enter_self();
		step(SCL_IDLE_CYCLE, 12'h000, 1'b1);
		check(dev_state, ST_SELF_REC, "recovery");
		dwell(ST_SELF_REC, ROW_CYCLE_CYC - 1, 1'b1, SCL_IDLE_CYCLE);
		enter_self();
		step(SCL_DESELECT, 12'h000, 1'b1);
		step(SCL_DESELECT, 12'h000, 1'b0);
		check(dev_state, ST_POWER_DOWN, "drop in recovery");
		step(SCL_DESELECT, 12'h000, 1'b1);
		check(dev_state, ST_IDLE, "exit to idle");
		// Undefined afterwards, so a reset follows each refusal
		enter_self();
		step(SCL_READ, 12'h000, 1'b1);
		check(illegal_cmd, 1'b1, "column on wake");
		do_reset();
		enter_self();
		step(SCL_DESELECT, 12'h000, 1'b1);
		step(SCL_ROW_CLOSE, 12'h000, 1'b0);
		check(illegal_cmd, 1'b1, "row on drop");
		do_reset();
		$display("self-retention test done");
	endtask
	// ==========================================================
	// Verdict, watchdog and main sequence
	// ==========================================================
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// About 100 cycles are needed; twenty times that means a hang
	initial begin
		#(CLK_PERIOD_NS * 2000);
		fails++;
		print_verdict();
	end
	initial begin
		exp_mode = 12'h000;
		do_reset();
		t_reset();
		t_busy(SCL_SETUP_LOAD, ST_SETUP, SETUP_LOAD_CYCLES);
		t_busy(SCL_REFRESH, ST_REFRESH, ROW_CLOSE_CYC);
		t_write();
		t_power();
		t_self();
		print_verdict();
	end
endmodule
`default_nettype wire
